/* File: src/adc_result_coding_and_control.sv */
/*
  control and result coding for a single-channel converter: output coding,
  input source routing, open-sensor test currents and full reset.
  assumes the modulator delivers a signed input sample scaled to 2^N per
  reference, and that configuration words arrive already decoded.
*/
`timescale 1ns/100ps
module adc_result_coding_and_control
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned N           = RESULT_WIDTH_HIGH,
  parameter int unsigned WAIT_CYCLES = RESET_WAIT_CYCLES
)
(
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  // serial pins
  input  wire logic                sclk_i,
  input  wire logic                din_i,
  input  wire logic                cs_n_i,
  // decoded configuration write
  input  wire logic                cfg_wr_i,
  input  wire logic                polarity_unipolar_i,
  input  wire logic                open_sensor_test_enable_i,
  input  wire logic [2:0]          input_source_select_i,
  // modulator sample
  input  wire logic                sample_valid_i,
  input  wire logic signed [N:0]   sample_i,
  input  wire logic                ref_absent_i,
  // coded result
  output logic                     result_valid_o,
  output logic [N-1:0]             result_o,
  // analog controls
  output logic                     test_current_source_o,
  output logic                     test_current_sink_o,
  output logic                     supply_atten_en_o,
  output logic                     temp_sensor_en_o,
  output logic                     internal_ref_sel_o,
  output logic                     polarity_unipolar_o,
  // reset status
  output logic                     core_reset_o,
  output logic                     access_ready_o,
  output logic                     wait_comm_o
);

  localparam int unsigned W  = N + GAIN_SHIFT + 3;
  localparam int unsigned CW = $clog2(WAIT_CYCLES + 1);
  localparam logic signed [W-1:0] CODE_MAX  = W'((64'(1) << N) - 1);
  localparam logic signed [W-1:0] CODE_SPAN = W'(64'(1) << N);
  typedef enum logic [1:0] {ST_HOLDOFF, ST_WAIT_COMM, ST_ACTIVE} iface_state_t;

  // ----------------------------------------------------------------
  // front end and full reset
  // ----------------------------------------------------------------
  serial_sync_if sync_bus ();
  logic full_rst_n;

  assign full_rst_n = rst_n_i & ~sync_bus.ones_reset;

  serial_front_end u_front
  (
    .ref_clk_i    (ref_clk_i),
    .full_rst_n_i (rst_n_i),
    .sclk_pin_i   (sclk_i),
    .din_pin_i    (din_i),
    .cs_n_pin_i   (cs_n_i),
    .sync_o       (sync_bus.front)
  );

  // ----------------------------------------------------------------
  // coding
  // ----------------------------------------------------------------
  // clamp to the n-bit code range; signed bounds keep every compare signed
  function automatic logic [N-1:0] sat_code(input logic signed [W-1:0] v);
    return (v < 0) ? '0 : ((v > CODE_MAX) ? '1 : v[N-1:0]);
  endfunction : sat_code

  logic signed [W-1:0] scaled;
  logic [N-1:0]        code_nxt, result_r;
  logic                valid_nxt, valid_r;
  logic                polarity_r, polarity_nxt;
  logic                test_en_r, test_en_nxt;
  logic [2:0]          source_r, source_nxt;
  logic                atten_r, atten_nxt, temp_r, temp_nxt, iref_r, iref_nxt;
  iface_state_t        state_r, state_nxt;
  logic [CW-1:0]       wait_cnt_r, wait_cnt_nxt;
  logic                core_rst_r, core_rst_nxt, ready_r, wcomm_r;

  always_comb
  begin
    scaled = W'(sample_i) <<< GAIN_SHIFT;
    if (ref_absent_i)
    begin
      code_nxt = '1;
    end
    else if (polarity_r)
    begin
      code_nxt = sat_code(scaled);
    end
    else
    begin
      code_nxt = sat_code((scaled + CODE_SPAN) >>> 1);
    end
    valid_nxt = sample_valid_i & full_rst_n;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!full_rst_n)
    begin
      result_r <= '0;
      valid_r  <= 1'b0;
    end
    else
    begin
      valid_r <= valid_nxt;
      if (sample_valid_i)
      begin
        result_r <= code_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  always_comb
  begin
    polarity_nxt = polarity_r;
    test_en_nxt  = test_en_r;
    source_nxt   = source_r;
    if (cfg_wr_i && state_r != ST_HOLDOFF)
    begin
      polarity_nxt = polarity_unipolar_i;
      test_en_nxt  = open_sensor_test_enable_i;
      source_nxt   = input_source_select_i;
    end
    atten_nxt = (source_nxt == SRC_SUPPLY_MON);
    temp_nxt  = (source_nxt == SRC_TEMP_SENSOR);
    iref_nxt  = atten_nxt | temp_nxt;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!full_rst_n)
    begin
      polarity_r <= POLARITY_UNIPOLAR_RST;
      test_en_r  <= TEST_ENABLE_RST;
      source_r   <= SOURCE_SELECT_RST;
      atten_r    <= 1'b0;
      temp_r     <= 1'b0;
      iref_r     <= 1'b0;
    end
    else
    begin
      polarity_r <= polarity_nxt;
      test_en_r  <= test_en_nxt;
      source_r   <= source_nxt;
      atten_r    <= atten_nxt;
      temp_r     <= temp_nxt;
      iref_r     <= iref_nxt;
    end
  end

  // ----------------------------------------------------------------
  // reset holdoff and interface state
  // ----------------------------------------------------------------
  // config writes during the holdoff are dropped; the host must not send them
  always_comb
  begin
    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    core_rst_nxt = 1'b0;
    case (state_r)
      ST_HOLDOFF:
      begin
        if (wait_cnt_r == CW'(WAIT_CYCLES - 1))
        begin
          state_nxt = ST_WAIT_COMM;
        end
        else
        begin
          wait_cnt_nxt = wait_cnt_r + CW'(1);
        end
      end
      ST_WAIT_COMM:
      begin
        if (sync_bus.sclk_rise && !sync_bus.cs_n_level)
        begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE:
      begin
        if (sync_bus.cs_n_level)
        begin
          state_nxt = ST_WAIT_COMM;
        end
      end
      default:
      begin
        state_nxt = ST_HOLDOFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!full_rst_n)
    begin
      state_r    <= ST_HOLDOFF;
      wait_cnt_r <= '0;
      core_rst_r <= 1'b1;
      ready_r    <= 1'b0;
      wcomm_r    <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      core_rst_r <= core_rst_nxt;
      ready_r    <= (state_nxt != ST_HOLDOFF);
      wcomm_r    <= (state_nxt == ST_WAIT_COMM);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign result_valid_o        = valid_r;
  assign result_o              = result_r;
  assign test_current_source_o = test_en_r;
  assign test_current_sink_o   = test_en_r;
  assign supply_atten_en_o     = atten_r;
  assign temp_sensor_en_o      = temp_r;
  assign internal_ref_sel_o    = iref_r;
  assign polarity_unipolar_o   = polarity_r;
  assign core_reset_o          = core_rst_r;
  assign access_ready_o        = ready_r;
  assign wait_comm_o           = wcomm_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence cfg_write_s(logic [2:0] src);
    cfg_wr_i && state_r != ST_HOLDOFF && input_source_select_i == src;
  endsequence

  chk_uni_zero: assert property (@(posedge ref_clk_i) disable iff (!full_rst_n)
    sample_valid_i && polarity_r && !ref_absent_i && sample_i == 0 |=> result_o == '0)
    else $error("unipolar zero not coded as zero");
  chk_bip_mid: assert property (@(posedge ref_clk_i) disable iff (!full_rst_n)
    sample_valid_i && !polarity_r && !ref_absent_i && sample_i == 0
    |=> result_o == N'(64'(1) << (N - 1)))
    else $error("bipolar zero not midscale");
  chk_gain_step: assert property (@(posedge ref_clk_i) disable iff (!full_rst_n)
    sample_valid_i && polarity_r && !ref_absent_i && sample_i == 1 |=> result_o == N'(GAIN_FACTOR))
    else $error("gain of one step wrong");
  chk_ref_sat: assert property (@(posedge ref_clk_i) disable iff (!full_rst_n)
    sample_valid_i && ref_absent_i |=> result_o == '1 && result_valid_o)
    else $error("missing reference not saturated");
  chk_ones_default: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sync_bus.ones_reset |=> !test_current_source_o && !polarity_unipolar_o && core_reset_o && !access_ready_o)
    else $error("serial reset did not restore defaults");
  chk_currents_pair: assert property (@(posedge ref_clk_i) disable iff (!full_rst_n)
    test_current_source_o == test_current_sink_o)
    else $error("test currents disagree");
  chk_currents_off: assert property (@(posedge ref_clk_i) disable iff (!full_rst_n)
    cfg_wr_i && state_r != ST_HOLDOFF && !open_sensor_test_enable_i
    |=> !test_current_source_o && !test_current_sink_o)
    else $error("test currents not off");
  chk_supply_mon: assert property (@(posedge ref_clk_i) disable iff (!full_rst_n)
    cfg_write_s(SRC_SUPPLY_MON) |=> supply_atten_en_o && internal_ref_sel_o && !temp_sensor_en_o)
    else $error("supply monitor not routed");
  chk_temp_mon: assert property (@(posedge ref_clk_i) disable iff (!full_rst_n)
    cfg_write_s(SRC_TEMP_SENSOR) |=> temp_sensor_en_o && internal_ref_sel_o && !supply_atten_en_o)
    else $error("temperature sensor not routed");
  chk_holdoff_end: assert property (@(posedge ref_clk_i) disable iff (!full_rst_n)
    state_r == ST_HOLDOFF && wait_cnt_r == CW'(WAIT_CYCLES - 1) |=> wait_comm_o && access_ready_o)
    else $error("holdoff did not end in wait state");

endmodule : adc_result_coding_and_control

/* File: src/adc_ctrl_pkg.sv */
/*
  constants shared by the converter control block: coding, input source codes,
  reset defaults and timing.
  assumes a single 250 MHz clock.
*/
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // coding
  // ----------------------------------------------------------------
  localparam int unsigned RESULT_WIDTH_LOW  = 16;
  localparam int unsigned RESULT_WIDTH_HIGH = 24;
  localparam int unsigned GAIN_FACTOR       = 128;
  localparam int unsigned GAIN_SHIFT        = 7;

  // ----------------------------------------------------------------
  // input source field
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_SUPPLY_MON  = 3'h7;
  localparam logic [2:0] SRC_TEMP_SENSOR = 3'h6;

  // ----------------------------------------------------------------
  // configuration defaults after any reset
  // ----------------------------------------------------------------
  localparam logic       POLARITY_UNIPOLAR_RST = 1'h0;
  localparam logic       TEST_ENABLE_RST       = 1'h0;
  localparam logic [2:0] SOURCE_SELECT_RST     = 3'h0;

  // ----------------------------------------------------------------
  // serial reset and timing
  // ----------------------------------------------------------------
  localparam int unsigned ONES_RESET_COUNT = 32;
  localparam int unsigned ONES_CNT_WIDTH   = 6;
  localparam int unsigned CLK_FREQ_MHZ     = 250;
  localparam int unsigned RESET_WAIT_US    = 500;
  localparam int unsigned RESET_WAIT_CYCLES = RESET_WAIT_US * CLK_FREQ_MHZ;

endpackage : adc_ctrl_pkg

/* File: src/serial_sync_if.sv */
/*
  carrier between the serial pin front end and the control logic.
  assumes both ends run on ref_clk_i.
*/
`timescale 1ns/100ps
interface serial_sync_if;
  logic sclk_rise;
  logic din_level;
  logic cs_n_level;
  logic ones_reset;

  modport front
  (
    output sclk_rise,
    output din_level,
    output cs_n_level,
    output ones_reset
  );
  modport ctl
  (
    input  sclk_rise,
    input  din_level,
    input  cs_n_level,
    input  ones_reset
  );
endinterface : serial_sync_if

/* File: src/serial_front_end.sv */
/*
  synchronises the serial pins and spots a run of consecutive ones on din.
  assumes pins are asynchronous to ref_clk_i and sclk is far slower than it.
*/
`timescale 1ns/100ps
module serial_front_end
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          full_rst_n_i,
  // pins
  input  wire logic          sclk_pin_i,
  input  wire logic          din_pin_i,
  input  wire logic          cs_n_pin_i,
  // to control logic
  serial_sync_if.front       sync_o
);

  // ----------------------------------------------------------------
  // three-stage synchronisers, change taken when stages two and three agree
  // ----------------------------------------------------------------
  logic [2:0] s1_r, s2_r, s3_r, stable_r;
  logic [2:0] stable_nxt;
  logic [ONES_CNT_WIDTH-1:0] ones_cnt_r, ones_cnt_nxt;
  logic       ones_reset_r, ones_reset_nxt;
  logic       rise_r, rise_nxt;

  always_comb
  begin
    stable_nxt = stable_r;
    for (int i = 0; i < 3; i++)
    begin
      if (s2_r[i] == s3_r[i])
      begin
        stable_nxt[i] = s3_r[i];
      end
    end
    rise_nxt       = stable_nxt[0] & ~stable_r[0];
    ones_cnt_nxt   = ones_cnt_r;
    ones_reset_nxt = 1'b0;
    // a zero or a deselect breaks the run
    if (stable_r[2] || !stable_r[1])
    begin
      ones_cnt_nxt = '0;
    end
    else if (rise_r)
    begin
      if (ones_cnt_r == ONES_CNT_WIDTH'(ONES_RESET_COUNT - 1))
      begin
        ones_cnt_nxt   = '0;
        ones_reset_nxt = 1'b1;
      end
      else
      begin
        ones_cnt_nxt = ones_cnt_r + ONES_CNT_WIDTH'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    s1_r <= {cs_n_pin_i, din_pin_i, sclk_pin_i};
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (!full_rst_n_i)
    begin
      stable_r     <= 3'h5; // sclk idles high: no false rise after reset
      rise_r       <= 1'b0;
      ones_cnt_r   <= '0;
      ones_reset_r <= 1'b0;
    end
    else
    begin
      stable_r     <= stable_nxt;
      rise_r       <= rise_nxt;
      ones_cnt_r   <= ones_cnt_nxt;
      ones_reset_r <= ones_reset_nxt;
    end
  end

  assign sync_o.sclk_rise  = rise_r;
  assign sync_o.din_level  = stable_r[1];
  assign sync_o.cs_n_level = stable_r[2];
  assign sync_o.ones_reset = ones_reset_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_ones_run_fires: assert property (@(posedge ref_clk_i) disable iff (!full_rst_n_i)
    ones_reset_r |-> $past(ones_cnt_r, 1) == ONES_CNT_WIDTH'(ONES_RESET_COUNT - 1))
    else $error("ones reset without a full run");

endmodule : serial_front_end

/* File: sim/host_serial_model.sv */
/*
  host side of the serial link: sends frames of ones on din under chip select.
  assumes ref_clk_i runs far faster than the serial clock it makes.
*/
`timescale 1ns/100ps
module host_serial_model
(
  // clock
  input  wire logic ref_clk_i,
  // serial pins
  output logic      sclk_o,
  output logic      din_o,
  output logic      cs_n_o
);
  // ----------------------------------------------------------------
  // frame driver
  // ----------------------------------------------------------------
  // sclk idles high and stands still between frames
  initial
  begin
    sclk_o = 1'b1;
    din_o  = 1'b0;
    cs_n_o = 1'b1;
  end

  task automatic tick;
    repeat (10) @(posedge ref_clk_i);
  endtask : tick

  // n_ones ones, then an optional zero that breaks the run
  task automatic frame(input int n_ones, input bit tail_zero);
    cs_n_o <= 1'b0;
    tick();
    for (int i = 0; i < n_ones + int'(tail_zero); i++)
    begin
      sclk_o <= 1'b0;
      din_o  <= (i < n_ones);
      tick();
      sclk_o <= 1'b1;
      tick();
    end
    cs_n_o <= 1'b1;
    // a deselected line must not look like a held value
    din_o  <= ~din_o;
    tick();
  endtask : frame
endmodule : host_serial_model

/* File: sim/adc_result_coding_and_control_bench.sv */
/*
  self-checking bench: coding, source decode, test currents, resets.
  assumes the 16-bit variant and a holdoff shortened to 20 cycles.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
  end
module adc_result_coding_and_control_bench;
  import adc_ctrl_pkg::*;
  localparam int NW = 16;
  localparam int WT = 20;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 sclk, din, cs_n;
  logic                 cfg_wr = 1'b0;
  logic                 pol = 1'b0;
  logic                 tst = 1'b0;
  logic [2:0]           src = 3'h0;
  logic                 s_vld = 1'b0;
  logic signed [NW:0]   smp = '0;
  logic                 r_abs = 1'b0;
  logic                 r_vld, t_src, t_snk, sup_en, tmp_en, iref, pol_o, core_rst, rdy, wcomm;
  logic [NW-1:0]        res;
  int                   err_total = 0;
  int                   n_tests = 0;
  bit                   seen;

  always #2 clk = ~clk;

  host_serial_model i_host (.ref_clk_i(clk), .sclk_o(sclk), .din_o(din), .cs_n_o(cs_n));

  adc_result_coding_and_control #(.N(NW), .WAIT_CYCLES(WT)) i_dut
  (
    .ref_clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .din_i(din), .cs_n_i(cs_n),
    .cfg_wr_i(cfg_wr), .polarity_unipolar_i(pol), .open_sensor_test_enable_i(tst),
    .input_source_select_i(src), .sample_valid_i(s_vld), .sample_i(smp), .ref_absent_i(r_abs),
    .result_valid_o(r_vld), .result_o(res), .test_current_source_o(t_src),
    .test_current_sink_o(t_snk), .supply_atten_en_o(sup_en), .temp_sensor_en_o(tmp_en),
    .internal_ref_sel_o(iref), .polarity_unipolar_o(pol_o), .core_reset_o(core_rst),
    .access_ready_o(rdy), .wait_comm_o(wcomm)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [NW-1:0] exp_code(input int s, input bit uni, input bit absent);
    longint sc;
    sc = longint'(s) * 128;
    if (!uni)
      sc = (sc + (longint'(1) << NW)) >>> 1;
    if (absent || sc > (longint'(1) << NW) - 1)
      return '1;
    return (sc < 0) ? '0 : NW'(sc);
  endfunction : exp_code

  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (rdy !== 1'b1 && cnt < 200)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask : wait_ready

  task automatic cfg(input bit p, input bit t, input logic [2:0] s);
    @(posedge clk);
    cfg_wr <= 1'b1;
    pol    <= p;
    tst    <= t;
    src    <= s;
    @(posedge clk);
    cfg_wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : cfg

  task automatic defaults_ok;
    `CHK("pol", 1'b0, pol_o)
    `CHK("tsrc", 1'b0, t_src)
    `CHK("supply", 1'b0, sup_en)
    `CHK("temp", 1'b0, tmp_en)
  endtask : defaults_ok

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup;
    int cnt;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cfg_wr <= 1'b1;
    pol    <= 1'b1;
    #1;
    `CHK("core_rst", 1'b1, core_rst)
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1;
    `CHK("core_rst", 1'b0, core_rst)
    wait_ready(cnt);
    `CHK("holdoff", 1'b1, cnt >= WT - 2 && cnt <= WT + 1)
    defaults_ok();
    `CHK("core_rst", 1'b0, core_rst)
    `CHK("wait_comm", 1'b1, wcomm)
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_config;
    // host waits out the holdoff before these writes; t_powerup writes during it
    `CHK("ready", 1'b1, rdy)
    for (int c = 0; c < 8; c++)
    begin
      cfg(c[0], 1'b1, c[2:0]);
      `CHK("tsrc", 1'b1, t_src)
      `CHK("tsnk", 1'b1, t_snk)
      `CHK("pol", c[0], pol_o)
      `CHK("supply", c == 7, sup_en)
      `CHK("temp", c == 6, tmp_en)
      `CHK("iref", c >= 6, iref)
    end
    cfg(1'b0, 1'b0, 3'h0);
    `CHK("tsrc", 1'b0, t_src)
    `CHK("tsnk", 1'b0, t_snk)
    $display("test config done");
  endtask : t_config

  task automatic t_coding;
    int vals [6] = '{0, 256, 511, 512, 600, -512};
    for (int u = 0; u < 3; u++)
    begin
      cfg(u[0], 1'b0, 3'h0);
      foreach (vals[k])
      begin
        @(posedge clk);
        s_vld <= 1'b1;
        smp   <= (NW+1)'(vals[k]);
        r_abs <= (u == 2);
        @(posedge clk);
        s_vld <= 1'b0;
        #1;
        `CHK("valid", 1'b1, r_vld)
        `CHK("result", exp_code(vals[k], u[0], u == 2), res)
      end
    end
    r_abs <= 1'b0;
    $display("test coding done");
  endtask : t_coding

  task automatic t_serial;
    int cnt;
    cfg(1'b1, 1'b1, 3'h6);
    fork
      i_host.frame(31, 1'b1);
      begin
        repeat (100) @(posedge clk);
        `CHK("wait_comm", 1'b0, wcomm)
      end
    join
    `CHK("pol kept", 1'b1, pol_o)
    `CHK("wait_comm", 1'b1, wcomm)
    seen = 1'b0;
    fork
      i_host.frame(32, 1'b0);
      begin
        for (int i = 0; i < 900 && !seen; i++)
        begin
          @(posedge clk);
          #1;
          seen = (core_rst === 1'b1);
        end
        @(posedge clk);
        #1;
        `CHK("ready", 1'b0, rdy)
      end
    join
    `CHK("core_rst", 1'b1, seen)
    wait_ready(cnt);
    defaults_ok();
    `CHK("wait_comm", 1'b1, wcomm)
    $display("test serial done");
  endtask : t_serial

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  initial
  begin
    t_powerup();
    t_config();
    t_coding();
    t_serial();
    finish_test();
  end

  // the tests need about 1500 cycles; this is well beyond
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule : adc_result_coding_and_control_bench
